// ### rtl/coord_time_base_feed_control.sv
// Coordinate-system time-base, blending, arc and feedrate supervision
`timescale 1ns/10ps
`include "coord_time_base_map.svh"
module coord_time_base_feed_control (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Panel start inputs, asynchronous pins
	input wire logic panel_go_low,
	input wire logic panel_single_low,
	// Configuration
	input wire logic [14:0] default_program_select,
	input wire logic blend_disable_flag,
	input wire logic [15:0] time_base_source_pointer,
	input wire logic [23:0] time_base_slew_rate,
	input wire logic [23:0] hold_decel_rate,
	input wire logic [31:0] arc_error_limit,
	input wire logic [31:0] feedrate_ceiling,
	input wire logic [15:0] servo_divider,
	// Host commands, one-cycle pulses
	input wire logic pick_program,
	input wire logic [14:0] pick_program_num,
	input wire logic execute_all,
	input wire logic one_move_go,
	input wire logic pause_motion,
	input wire logic abort_run,
	input wire logic [23:0] time_base_order,
	input wire logic time_base_order_wr,
	// Alternate hardware time-base source
	input wire logic [15:0] hw_source_addr,
	input wire logic [23:0] hw_time_base,
	// Continuous-motion status bit written during a run
	input wire logic status_wr,
	input wire logic [7:0] status_wdata,
	// Arc check request
	input wire logic arc_check,
	input wire logic arc_center_vector_form,
	input wire logic [31:0] arc_chord,
	input wire logic [31:0] arc_radius,
	// Feedrate request
	input wire logic feed_valid,
	input wire logic [31:0] vector_speed_word,
	// Outputs
	output logic run_start,
	output logic single_step,
	output logic [14:0] run_program,
	output logic running,
	output logic blend_enable,
	output logic dwell_insert,
	output logic [7:0] cs_status,
	output logic [23:0] actual_time_base,
	output logic time_base_settled,
	output logic arc_spiral,
	output logic arc_error,
	output logic [31:0] feedrate_out,
	output logic feed_clamped,
	output logic servo_tick
);
	// ------------------------------------------------------------
	// Input synchronisers and edges
	// ------------------------------------------------------------
	logic [1:0] go_sync_reg;
	logic [1:0] single_sync_reg;
	logic go_prev_reg;
	logic single_prev_reg;
	logic go_fall;
	logic single_fall;

	// Two flops on each pin; edges read only the second stage
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			go_sync_reg <= 2'h3;
			single_sync_reg <= 2'h3;
			go_prev_reg <= 1'b1;
			single_prev_reg <= 1'b1;
		end else begin
			go_sync_reg <= {go_sync_reg[0], panel_go_low};
			single_sync_reg <= {single_sync_reg[0], panel_single_low};
			go_prev_reg <= go_sync_reg[1];
			single_prev_reg <= single_sync_reg[1];
		end
	end

	assign go_fall = go_prev_reg & ~go_sync_reg[1];
	assign single_fall = single_prev_reg & ~single_sync_reg[1];

	// ------------------------------------------------------------
	// Servo cycle divider
	// ------------------------------------------------------------
	logic [15:0] div_count_reg;

	// Tick once per servo cycle; zero divider falls back to the default
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			div_count_reg <= 16'h0000;
			servo_tick <= 1'b0;
		end else if (div_count_reg >= ((servo_divider == 16'h0000) ?
				`SERVO_DIV_DEFAULT : servo_divider) - 16'h0001) begin
			div_count_reg <= 16'h0000;
			servo_tick <= 1'b1;
		end else begin
			div_count_reg <= div_count_reg + 16'h0001;
			servo_tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Program selection
	// ------------------------------------------------------------
	logic host_picked_reg;
	logic [14:0] host_prog_reg;
	logic start_any;
	logic panel_start;

	assign panel_start = go_fall | single_fall;
	assign start_any = execute_all | one_move_go | panel_start;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			host_picked_reg <= 1'b0;
			host_prog_reg <= `PROG_DEFAULT;
		end else if (pick_program) begin
			host_picked_reg <= 1'b1;
			host_prog_reg <= pick_program_num;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			run_program <= `PROG_DEFAULT;
			run_start <= 1'b0;
			single_step <= 1'b0;
		end else begin
			run_start <= start_any;
			single_step <= one_move_go | single_fall;
			if (start_any) begin
				run_program <= host_picked_reg ? host_prog_reg : default_program_select;
			end
		end
	end

	// ------------------------------------------------------------
	// Run state
	// ------------------------------------------------------------
	coord_time_base_pkg::run_state_t state_reg;
	logic arc_fault;

	// An arc fault takes precedence over any start in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= coord_time_base_pkg::RUN_IDLE;
		end else begin
			case (state_reg)
				coord_time_base_pkg::RUN_IDLE,
				coord_time_base_pkg::RUN_HOLD,
				coord_time_base_pkg::RUN_FAULT: begin
					if (start_any && !arc_fault) begin
						state_reg <= coord_time_base_pkg::RUN_ACTIVE;
					end
				end
				coord_time_base_pkg::RUN_ACTIVE: begin
					if (arc_fault) begin
						state_reg <= coord_time_base_pkg::RUN_FAULT;
					end else if (abort_run) begin
						state_reg <= coord_time_base_pkg::RUN_IDLE;
					end else if (pause_motion) begin
						state_reg <= coord_time_base_pkg::RUN_HOLD;
					end
				end
				default: begin
					state_reg <= coord_time_base_pkg::RUN_IDLE;
				end
			endcase
		end
	end

	assign running = (state_reg == coord_time_base_pkg::RUN_ACTIVE);

	// ------------------------------------------------------------
	// Blend control
	// ------------------------------------------------------------
	// flag sampled at start only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cs_status <= 8'h00;
		end else if (execute_all | one_move_go | panel_start) begin
			cs_status[`CONT_MOTION_BIT] <= ~blend_disable_flag;
		end else if (status_wr) begin
			cs_status <= status_wdata;
		end
	end

	assign blend_enable = cs_status[`CONT_MOTION_BIT];
	assign dwell_insert = ~cs_status[`CONT_MOTION_BIT];

	// ------------------------------------------------------------
	// Time-base source and slew
	// ------------------------------------------------------------
	logic [23:0] order_reg;
	logic [23:0] tb_source;
	logic [23:0] tb_target;
	logic [23:0] tb_rate;
	logic hold_ramp_reg;

	// Commanded value, reset to one ms per servo tick (full speed)
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			order_reg <= `TB_ONE_MS;
		end else if (time_base_order_wr) begin
			order_reg <= time_base_order;
		end
	end

	// pointer selects the source; both use the same scale
	// hardware value followed under the slew limit
	assign tb_source = (time_base_source_pointer == `TB_SRC_DEFAULT) ? order_reg :
		(time_base_source_pointer == hw_source_addr) ? hw_time_base : order_reg;

	// hold ramps use the hold rate, also on the way back up
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hold_ramp_reg <= 1'b0;
		end else if (pause_motion) begin
			hold_ramp_reg <= 1'b1;
		end else if (time_base_order_wr) begin
			hold_ramp_reg <= 1'b0;
		end else if (state_reg == coord_time_base_pkg::RUN_ACTIVE && time_base_settled) begin
			hold_ramp_reg <= 1'b0;
		end
	end

	assign tb_target = (state_reg == coord_time_base_pkg::RUN_HOLD) ? 24'h000000 : tb_source;
	assign tb_rate = hold_ramp_reg ? hold_decel_rate : time_base_slew_rate;

	time_base_slewer u_slewer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.step_en(servo_tick),
		.target(tb_target),
		.rate(tb_rate),
		.value(actual_time_base),
		.settled(time_base_settled)
	);

	// ------------------------------------------------------------
	// Arc tolerance
	// ------------------------------------------------------------
	logic [32:0] two_r;
	logic [32:0] excess;
	logic over_2r;

	assign two_r = {arc_radius, 1'b0};
	assign over_2r = {1'b0, arc_chord} > two_r;
	assign excess = {1'b0, arc_chord} - two_r;
	// error only for radius arcs beyond a nonzero limit
	assign arc_fault = arc_check & ~arc_center_vector_form & over_2r &
		(arc_error_limit != 32'h00000000) & (excess > {1'b0, arc_error_limit});

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			arc_spiral <= 1'b0;
			arc_error <= 1'b0;
		end else begin
			arc_spiral <= arc_check & ~arc_center_vector_form & over_2r & ~arc_fault;
			arc_error <= arc_fault;
		end
	end

	// ------------------------------------------------------------
	// Feedrate ceiling
	// ------------------------------------------------------------
	// clamp only with nonzero ceiling
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			feedrate_out <= 32'h00000000;
			feed_clamped <= 1'b0;
		end else if (feed_valid) begin
			if (feedrate_ceiling != 32'h00000000 && vector_speed_word > feedrate_ceiling) begin
				feedrate_out <= feedrate_ceiling;
				feed_clamped <= 1'b1;
			end else begin
				feedrate_out <= vector_speed_word;
				feed_clamped <= 1'b0;
			end
		end
	end
endmodule

// ### rtl/coord_time_base_map.svh
// Constants for the coordinate-system time-base and feed supervision block
`ifndef COORD_TIME_BASE_MAP_SVH
`define COORD_TIME_BASE_MAP_SVH
`define TB_ONE_MS 24'h800000
`define TB_SLEW_DEFAULT 24'h00066c
`define TB_HOLD_DEFAULT 24'h00066c
`define TB_SRC_DEFAULT 16'h0806
`define PROG_DEFAULT 15'h0000
`define CONT_MOTION_BIT 4
`define SERVO_DIV_DEFAULT 16'h4510
`endif

// ### rtl/coord_time_base_pkg.sv
// Types for the coordinate-system time-base and feed supervision block
package coord_time_base_pkg;
	typedef enum logic [1:0] {
		RUN_IDLE = 2'b00,
		RUN_ACTIVE = 2'b01,
		RUN_HOLD = 2'b10,
		RUN_FAULT = 2'b11
	} run_state_t;
endpackage

// ### rtl/time_base_slewer.sv
// Slews a value toward a target by a bounded step on each enable
`timescale 1ns/10ps
module time_base_slewer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Control
	input wire logic step_en,
	input wire logic [23:0] target,
	input wire logic [23:0] rate,
	// Result
	output logic [23:0] value,
	output logic settled
);
	logic [23:0] value_reg;
	logic [23:0] value_next;
	logic [23:0] diff;

	// Step clamped so it lands on the target, never past it
	always_comb begin
		value_next = value_reg;
		if (target > value_reg) begin
			diff = target - value_reg;
			value_next = (diff > rate) ? value_reg + rate : target;
		end else begin
			diff = value_reg - target;
			value_next = (diff > rate) ? value_reg - rate : target;
		end
	end

	// Value updates only on the servo tick
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			value_reg <= 24'h000000;
		end else if (step_en) begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;
	assign settled = (value_reg == target);
endmodule

// ### testbench/coord_time_base_feed_control_assertions.sv
// Checker for the time-base and feed supervision block
`timescale 1ns/10ps
module coord_time_base_feed_control_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Inputs watched
	input wire logic blend_disable_flag,
	input wire logic [31:0] arc_error_limit,
	input wire logic [31:0] feedrate_ceiling,
	input wire logic execute_all,
	input wire logic one_move_go,
	input wire logic abort_run,
	input wire logic arc_check,
	input wire logic arc_center_vector_form,
	input wire logic [31:0] arc_chord,
	input wire logic [31:0] arc_radius,
	input wire logic feed_valid,
	input wire logic [31:0] vector_speed_word,
	// Outputs watched
	input wire logic running,
	input wire logic blend_enable,
	input wire logic dwell_insert,
	input wire logic [23:0] actual_time_base,
	input wire logic arc_spiral,
	input wire logic arc_error,
	input wire logic [31:0] feedrate_out,
	input wire logic feed_clamped,
	input wire logic servo_tick
);
	logic [33:0] two_r;
	logic over;
	logic big;
	logic radial;
	// Widened so twice the radius plus the limit never wraps
	assign two_r = {1'h0, arc_radius, 1'h0};
	assign over = {2'h0, arc_chord} > two_r;
	assign big = {2'h0, arc_chord} > two_r + {2'h0, arc_error_limit};
	assign radial = arc_check && !arc_center_vector_form;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_blend; (execute_all || one_move_go) && !abort_run |=>
		blend_enable == !$past(blend_disable_flag); endproperty
	a_blend: assert property (p_blend) else $error("blend not sampled at start");
	// blend off at start inserts the dwell
	property p_dwell; (execute_all || one_move_go) && blend_disable_flag |=>
		dwell_insert && !blend_enable; endproperty
	a_dwell: assert property (p_dwell) else $error("dwell and blend disagree");
	property p_step; $changed(actual_time_base) |-> $past(servo_tick); endproperty
	a_step: assert property (p_step) else $error("time base moved off tick");
	property p_clamp; feed_valid && feedrate_ceiling != 32'h0 &&
		vector_speed_word > feedrate_ceiling |=>
		feed_clamped && feedrate_out == $past(feedrate_ceiling); endproperty
	a_clamp: assert property (p_clamp) else $error("feed not clamped");
	property p_free; feed_valid && feedrate_ceiling == 32'h0 |=>
		!feed_clamped && feedrate_out == $past(vector_speed_word); endproperty
	a_free: assert property (p_free) else $error("feed altered without ceiling");
	property p_small; radial && over && !big |=> arc_spiral && !arc_error; endproperty
	a_small: assert property (p_small) else $error("small excess not spiral");
	property p_big; radial && arc_error_limit != 32'h0 && big |=> arc_error && !running; endproperty
	a_big: assert property (p_big) else $error("large excess not faulted");
	property p_zero; radial && arc_error_limit == 32'h0 && over |=> arc_spiral && !arc_error; endproperty
	a_zero: assert property (p_zero) else $error("zero limit raised error");
	property p_cvf; arc_check && arc_center_vector_form |=> !arc_error; endproperty
	a_cvf: assert property (p_cvf) else $error("center form raised error");
	c_start: cover property (execute_all);
	c_error: cover property (arc_error);
	c_clamp: cover property (feed_clamped);
endmodule
bind coord_time_base_feed_control coord_time_base_feed_control_assertions u_chk (.sys_clk, .resetn,
	.blend_disable_flag, .arc_error_limit, .feedrate_ceiling, .execute_all, .one_move_go,
	.abort_run, .arc_check, .arc_center_vector_form, .arc_chord, .arc_radius, .feed_valid,
	.vector_speed_word, .running, .blend_enable, .dwell_insert, .actual_time_base, .arc_spiral,
	.arc_error, .feedrate_out, .feed_clamped, .servo_tick);

// ### testbench/panel_model.sv
// Control-panel model driving the two start pins
`timescale 1ns/10ps
module panel_model (
	// Clock and press requests
	input wire logic sys_clk,
	input wire logic press_go,
	input wire logic press_single,
	// Start pins, pulled up when released
	output logic panel_go_low,
	output logic panel_single_low
);
	logic [2:0] go_cnt = 3'h0;
	logic [2:0] st_cnt = 3'h0;
	// pin low long enough to pass the synchroniser
	always_ff @(posedge sys_clk) begin
		go_cnt <= press_go ? 3'h6 : go_cnt - {2'h0, go_cnt != 3'h0};
		st_cnt <= press_single ? 3'h6 : st_cnt - {2'h0, st_cnt != 3'h0};
	end
	assign panel_go_low = go_cnt == 3'h0;
	assign panel_single_low = st_cnt == 3'h0;
endmodule

// ### testbench/test_coord_time_base_feed_control.sv
// Self-checking bench for the time-base and feed supervision block
`timescale 1ns/10ps
`include "coord_time_base_map.svh"
module test_coord_time_base_feed_control;
	logic sys_clk = 1'h0, resetn = 1'h0, press_go = 1'h0, press_single = 1'h0;
	logic blend_disable_flag = 1'h0, pick_program = 1'h0, execute_all = 1'h0, one_move_go = 1'h0;
	logic pause_motion = 1'h0, abort_run = 1'h0, time_base_order_wr = 1'h0, status_wr = 1'h0;
	logic arc_check = 1'h0, arc_center_vector_form = 1'h0, feed_valid = 1'h0;
	logic [14:0] default_program_select = 15'h7fff, pick_program_num = 15'h0123;
	logic [15:0] time_base_source_pointer = `TB_SRC_DEFAULT, servo_divider = 16'h0004;
	logic [15:0] hw_source_addr = 16'h0729;
	logic [23:0] time_base_slew_rate = 24'h300000, hold_decel_rate = 24'h200000;
	logic [23:0] time_base_order = 24'h000000, hw_time_base = 24'h7ff000;
	logic [31:0] arc_error_limit = 32'h0, feedrate_ceiling = 32'h0, arc_chord = 32'h0;
	logic [31:0] arc_radius = 32'h1f4, vector_speed_word = 32'h0;
	logic [7:0] status_wdata = 8'h00;
	logic panel_go_low, panel_single_low, run_start, single_step, running, blend_enable;
	logic dwell_insert, time_base_settled, arc_spiral, arc_error, feed_clamped, servo_tick;
	logic [14:0] run_program;
	logic [7:0] cs_status;
	logic [23:0] actual_time_base;
	logic [31:0] feedrate_out;
	logic [31:0] ch [6] = '{32'h3eb, 32'h3f2, 32'h3ed, 32'h7d0, 32'h7d0, 32'h3e8};
	logic [5:0] cv = 6'h10, sp = 6'h0d, er = 6'h02, lz = 6'h08;
	int bad_count = 0, cmp_count = 0, cycles = 0;
	coord_time_base_feed_control dut (.sys_clk, .resetn, .panel_go_low, .panel_single_low,
		.default_program_select, .blend_disable_flag, .time_base_source_pointer,
		.time_base_slew_rate, .hold_decel_rate, .arc_error_limit, .feedrate_ceiling,
		.servo_divider, .pick_program, .pick_program_num, .execute_all, .one_move_go,
		.pause_motion, .abort_run, .time_base_order, .time_base_order_wr, .hw_source_addr,
		.hw_time_base, .status_wr, .status_wdata, .arc_check, .arc_center_vector_form,
		.arc_chord, .arc_radius, .feed_valid, .vector_speed_word, .run_start, .single_step,
		.run_program, .running, .blend_enable, .dwell_insert, .cs_status, .actual_time_base,
		.time_base_settled, .arc_spiral, .arc_error, .feedrate_out, .feed_clamped, .servo_tick);
	panel_model far (.sys_clk, .press_go, .press_single, .panel_go_low, .panel_single_low);
	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;
	// Hang guard: the sequence needs about eighty cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			complete_run;
		end
	end
	// Inputs change a fixed 2 ns after each rising edge
	task step;
		@(posedge sys_clk);
		#2;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Returns just after the edge that took a servo tick
	task tick;
		int n;
		n = 0;
		while (servo_tick !== 1'h1 && n < 20) begin
			step;
			n++;
		end
		chk("tick", servo_tick, 1'h1);
		step;
	endtask
	task wait_start;
		int n;
		n = 0;
		while (run_start !== 1'h1 && n < 20) begin
			step;
			n++;
		end
		chk("started", run_start, 1'h1);
	endtask
	task feed(input logic [31:0] c, input logic [31:0] s, input logic [31:0] e, input logic k);
		feedrate_ceiling = c;
		vector_speed_word = s;
		feed_valid = 1'h1;
		step;
		chk("feed", feedrate_out, e);
		chk("clamped", {31'h0, feed_clamped}, {31'h0, k});
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) step;
		resetn = 1'h1;
		tick;
		chk("slew1", actual_time_base, 24'h300000);
		tick;
		tick;
		chk("slew3", actual_time_base, 24'h800000);
		chk("settled", time_base_settled, 1'h1);
		press_go = 1'h1;
		step;
		press_go = 1'h0;
		wait_start;
		chk("panel prog", run_program, 15'h7fff);
		abort_run = 1'h1;
		default_program_select = 15'h0000;
		step;
		abort_run = 1'h0;
		press_single = 1'h1;
		step;
		press_single = 1'h0;
		wait_start;
		chk("single", single_step, 1'h1);
		chk("single prog", run_program, 15'h0000);
		abort_run = 1'h1;
		step;
		abort_run = 1'h0;
		pick_program = 1'h1;
		step;
		pick_program = 1'h0;
		blend_disable_flag = 1'h1;
		execute_all = 1'h1;
		step;
		execute_all = 1'h0;
		chk("pick prog", run_program, 15'h0123);
		chk("dwell", dwell_insert, 1'h1);
		blend_disable_flag = 1'h0;
		step;
		chk("blend held", blend_enable, 1'h0);
		status_wdata = 8'h10;
		status_wr = 1'h1;
		step;
		status_wr = 1'h0;
		step;
		chk("blend status", blend_enable, 1'h1);
		chk("status", cs_status, 8'h10);
		tick;
		pause_motion = 1'h1;
		step;
		pause_motion = 1'h0;
		tick;
		chk("hold", actual_time_base, 24'h600000);
		tick;
		chk("hold2", actual_time_base, 24'h400000);
		one_move_go = 1'h1;
		step;
		one_move_go = 1'h0;
		tick;
		chk("resume", actual_time_base, 24'h600000);
		tick;
		chk("resume2", actual_time_base, 24'h800000);
		time_base_order = 24'h400000;
		time_base_order_wr = 1'h1;
		step;
		time_base_order_wr = 1'h0;
		tick;
		chk("order1", actual_time_base, 24'h500000);
		tick;
		chk("order2", actual_time_base, 24'h400000);
		time_base_source_pointer = 16'h0729;
		tick;
		chk("hw1", actual_time_base, 24'h700000);
		tick;
		chk("hw2", actual_time_base, 24'h7ff000);
		chk("running", running, 1'h1);
		for (int i = 0; i < 6; i++) begin
			arc_chord = ch[i];
			arc_error_limit = lz[i] ? 32'h0 : 32'h5;
			arc_center_vector_form = cv[i];
			arc_check = 1'h1;
			step;
			chk("arc error", arc_error, er[i]);
			if (!cv[i]) chk("arc spiral", arc_spiral, sp[i]);
		end
		arc_check = 1'h0;
		chk("faulted", running, 1'h0);
		feed(32'h3e8, 32'h5dc, 32'h3e8, 1'h1);
		feed(32'h3e8, 32'h3e8, 32'h3e8, 1'h0);
		feed(32'h0, 32'hffffffff, 32'hffffffff, 1'h0);
		feed_valid = 1'h0;
		complete_run;
	end
endmodule
